// File: rtl/activity_power_manager.sv
// power management unit: idle timers, power states, interrupt, throttle
// assumes software inputs are levels held by the management core
`timescale 1ns/10ps
module activity_power_manager
    import apm_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 sys_activity_in,
    input  wire logic                 hk_activity_in,
    input  wire logic                 periph_activity_in,
    input  wire logic [TMR_W-1:0]     doze_timeout_in,
    input  wire logic [TMR_W-1:0]     stby_timeout_in,
    input  wire logic [TMR_W-1:0]     suspend_throttle_out_timeout_in,
    input  wire logic [TMR_W-1:0]     hk_timeout_in,
    input  wire logic [TMR_W-1:0]     periph_timeout_in,
    input  wire logic [SRC_W-1:0]     irq_enable_in,
    input  wire logic [SRC_W-1:0]     irq_ack_in,
    input  wire logic                 state_req_in,
    input  wire apm_pkg::pwr_state_t  state_sel_in,
    input  wire logic [DUTY_W-1:0]    throttle_on_in,
    input  wire logic [DUTY_W-1:0]    throttle_doze_in,
    input  wire logic [DUTY_W-1:0]    throttle_stby_in,
    input  wire logic [PLANE_W-1:0]   plane_off_in,
    input  wire logic                 core_drained_in,
    output logic                      system_mgmt_interrupt_out,
    output logic [SRC_W-1:0]          irq_status_out,
    output apm_pkg::pwr_state_t       pwr_state_out,
    output logic                      suspend_throttle_out,
    output logic                      core_clk_stop_out,
    output logic [PLANE_W-1:0]        plane_enable_out,
    output logic                      periph_idle_out
);
    import apm_pkg::*;

    // ----------------------------------------
    // activity qualification
    // ----------------------------------------
    logic hk_burst_live;
    logic hk_expire;
    logic sys_act_q;
    logic sys_act_d;
    logic hk_act_q;
    logic hk_act_d;
    logic hk_window_q;
    logic hk_window_d;
    logic low_state;
    logic low_state_or_suspend_throttle_out;
    pwr_state_t state_q;
    pwr_state_t state_d;

    assign low_state = (state_q == PWR_DOZE) || (state_q == PWR_STBY);

    always_comb
    begin
        sys_act_d   = sys_activity_in;
        hk_act_d    = hk_activity_in;
        hk_window_d = hk_window_q;
        if (hk_activity_in && !hk_act_q && low_state)
        begin
            hk_window_d = 1'b1;
        end
        else if (hk_expire || !low_state)
        begin
            hk_window_d = 1'b0;
        end
    end

    // in doze or stand-by, housekeeping counts as activity only once a burst outlasts its timer
    assign hk_burst_live = hk_act_q && !(low_state && hk_window_q);

    logic act_any;
    assign act_any = sys_act_q || hk_burst_live;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sys_act_q   <= 1'b0;
            hk_act_q    <= 1'b0;
            hk_window_q <= 1'b0;
        end
        else
        begin
            sys_act_q   <= sys_act_d;
            hk_act_q    <= hk_act_d;
            hk_window_q <= hk_window_d;
        end
    end

    // ----------------------------------------
    // timers
    // ----------------------------------------
    logic [SRC_W-1:0] tmr_expire;
    logic [TMR_W-1:0] tmr_timeout [SRC_W];
    logic [SRC_W-1:0] tmr_act;
    logic [SRC_W-1:0] tmr_en;

    assign tmr_timeout[SRC_DOZE]   = doze_timeout_in;
    assign tmr_timeout[SRC_STBY]   = stby_timeout_in;
    assign tmr_timeout[SRC_SUSPEND_THROTTLE_OUT]   = suspend_throttle_out_timeout_in;
    assign tmr_timeout[SRC_WAKE]   = hk_timeout_in;
    assign tmr_timeout[SRC_PERIPH] = periph_timeout_in;
    assign tmr_act[SRC_DOZE]   = act_any;
    assign tmr_act[SRC_STBY]   = act_any;
    assign tmr_act[SRC_SUSPEND_THROTTLE_OUT]   = act_any;
    assign tmr_act[SRC_WAKE]   = !hk_window_q;
    assign tmr_act[SRC_PERIPH] = periph_activity_in;
    assign tmr_en[SRC_DOZE]    = state_q == PWR_ON;
    assign tmr_en[SRC_STBY]    = state_q == PWR_ON || state_q == PWR_DOZE;
    assign tmr_en[SRC_SUSPEND_THROTTLE_OUT]    = state_q != PWR_SUSPEND_THROTTLE_OUT;
    assign tmr_en[SRC_WAKE]    = 1'b1;
    assign tmr_en[SRC_PERIPH]  = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < SRC_W; gi++)
        begin : g_tmr
            idle_timer u_tmr (
                .clk_in      (clk_in),
                .rst_b_in    (rst_b_in),
                .enable_in   (tmr_en[gi]),
                .activity_in (tmr_act[gi]),
                .timeout_in  (tmr_timeout[gi]),
                .expire_out  (tmr_expire[gi])
            );
        end
    endgenerate

    assign hk_expire = tmr_expire[SRC_WAKE];

    // ----------------------------------------
    // interrupt sources
    // ----------------------------------------
    logic [SRC_W-1:0] src_event;
    logic [SRC_W-1:0] irq_q;
    logic [SRC_W-1:0] irq_d;
    logic             mgmt_irq_q;
    logic             mgmt_irq_d;
    logic             periph_idle_q;
    logic             periph_idle_d;

    always_comb
    begin
        src_event             = tmr_expire;
        src_event[SRC_WAKE]   = low_state_or_suspend_throttle_out && act_any;
        src_event[SRC_PERIPH] = tmr_expire[SRC_PERIPH];
        // set wins over acknowledge
        irq_d = ((irq_q & ~irq_ack_in) | src_event) & irq_enable_in;
        mgmt_irq_d = |irq_d;
        periph_idle_d = periph_idle_q;
        if (periph_activity_in)
        begin
            periph_idle_d = 1'b0;
        end
        else if (tmr_expire[SRC_PERIPH])
        begin
            periph_idle_d = 1'b1;
        end
    end

    assign low_state_or_suspend_throttle_out = state_q != PWR_ON;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            irq_q         <= SRC_NONE;
            mgmt_irq_q    <= 1'b0;
            periph_idle_q <= 1'b0;
        end
        else
        begin
            irq_q         <= irq_d;
            mgmt_irq_q    <= mgmt_irq_d;
            periph_idle_q <= periph_idle_d;
        end
    end

    chk_irq_holds: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        irq_q[SRC_DOZE] && !irq_ack_in[SRC_DOZE] && irq_enable_in[SRC_DOZE]
        |=> irq_q[SRC_DOZE])
        else $error("interrupt source dropped without acknowledge");
    chk_timer_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        tmr_expire[SRC_SUSPEND_THROTTLE_OUT] && irq_enable_in[SRC_SUSPEND_THROTTLE_OUT] |=> irq_q[SRC_SUSPEND_THROTTLE_OUT] ##1 mgmt_irq_q)
        else $error("suspend expiry gave no interrupt");
    chk_wake_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        state_q != PWR_ON && sys_act_q && irq_enable_in[SRC_WAKE] |=> irq_q[SRC_WAKE])
        else $error("activity in power-down gave no interrupt");
    chk_periph_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        tmr_expire[SRC_PERIPH] && !periph_activity_in |=> periph_idle_q)
        else $error("peripheral idle not flagged");

    // ----------------------------------------
    // power state and clock stop
    // ----------------------------------------
    logic       clk_stop_q;
    logic       clk_stop_d;

    always_comb
    begin
        state_d    = state_q;
        clk_stop_d = clk_stop_q;
        if (state_req_in)
        begin
            state_d = state_sel_in;
        end
        if (state_q == PWR_SUSPEND_THROTTLE_OUT && core_drained_in)
        begin
            clk_stop_d = 1'b1;
        end
        if (state_q != PWR_SUSPEND_THROTTLE_OUT || (state_req_in && state_sel_in != PWR_SUSPEND_THROTTLE_OUT))
        begin
            clk_stop_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_q    <= PWR_ON;
            clk_stop_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            clk_stop_q <= clk_stop_d;
        end
    end

    chk_stop_drained: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $rose(clk_stop_q) |-> $past(core_drained_in) && $past(state_q) == PWR_SUSPEND_THROTTLE_OUT)
        else $error("clock stopped before core drained");
    chk_resume_run: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        state_q != PWR_SUSPEND_THROTTLE_OUT |=> !clk_stop_q)
        else $error("clock still stopped outside suspend");
    chk_state_req: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        state_req_in |=> state_q == $past(state_sel_in))
        else $error("power state request not taken");
    chk_clk_stop_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        clk_stop_q && state_q == PWR_SUSPEND_THROTTLE_OUT && !state_req_in |=> clk_stop_q)
        else $error("clock restarted while suspend held");

    // ----------------------------------------
    // throttle modulation and planes
    // ----------------------------------------
    logic [DUTY_W-1:0]  phase_q;
    logic [DUTY_W-1:0]  phase_d;
    logic [DUTY_W-1:0]  duty;
    logic               throttle_q;
    logic               throttle_d;
    logic [PLANE_W-1:0] plane_q;
    logic [PLANE_W-1:0] plane_d;

    always_comb
    begin
        unique case (state_q)
            PWR_ON:   duty = throttle_on_in;
            PWR_DOZE: duty = throttle_doze_in;
            PWR_STBY: duty = throttle_stby_in;
            PWR_SUSPEND_THROTTLE_OUT: duty = DUTY_ZERO;
        endcase
        phase_d = phase_q + DUTY_ONE;
        // low asserts suspend for duty of each 16-clock frame
        throttle_d = !(phase_q < duty) && !(state_q == PWR_SUSPEND_THROTTLE_OUT);
        plane_d    = ~plane_off_in;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            phase_q    <= DUTY_ZERO;
            throttle_q <= 1'b1;
            plane_q    <= PLANE_ALL_ON;
        end
        else
        begin
            phase_q    <= phase_d;
            throttle_q <= throttle_d;
            plane_q    <= plane_d;
        end
    end

    chk_throttle_duty: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        state_q == PWR_ON && phase_q < throttle_on_in |=> !throttle_q)
        else $error("throttle not applied in on state");
    chk_plane_follow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ##1 plane_q == ~$past(plane_off_in))
        else $error("power plane output mismatch");
    chk_suspend_throttle_out_throttle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        state_q == PWR_SUSPEND_THROTTLE_OUT |=> !throttle_q)
        else $error("throttle released during suspend");

    assign system_mgmt_interrupt_out = mgmt_irq_q;
    assign irq_status_out            = irq_q;
    assign pwr_state_out             = state_q;
    assign suspend_throttle_out      = throttle_q;
    assign core_clk_stop_out         = clk_stop_q;
    assign plane_enable_out          = plane_q;
    assign periph_idle_out           = periph_idle_q;
endmodule : activity_power_manager

// File: rtl/apm_pkg.sv
// constants for the activity power manager
// assumes one 125 MHz clock and an active-low asynchronous reset
//
// Behaviour
// - a doze timer flags a short stretch with no system activity, the shortest of three.
// - a stand-by timer flags a medium stretch with no system activity, longer than doze.
// - a suspend timer flags a long stretch with no system activity, the longest of three.
// - each of the three timers can raise a management interrupt when it runs out.
// - system activity seen in any power-down state can raise a management interrupt.
// - there are three power-down states besides on: doze, stand-by and suspend.
// - a housekeeping timer absorbs short housekeeping bursts in doze or stand-by.
// - peripheral activity is watched by its own timer that flags a lack of it.
// - the suspend output is modulated to throttle performance in on, doze and stand-by; suspend holds it asserted.
// - power control outputs let software switch off individual supply planes.
// - suspend stops clocks only after the core reports its work drained.
// - leaving suspend restarts the core clock so it resumes where it stopped.
package apm_pkg;
    localparam int          TMR_W       = 16;
    localparam int          SRC_W       = 5;
    localparam int          PLANE_W     = 4;
    localparam int          DUTY_W      = 4;
    // interrupt source bits
    localparam int          SRC_DOZE    = 0;
    localparam int          SRC_STBY    = 1;
    localparam int          SRC_SUSPEND_THROTTLE_OUT    = 2;
    localparam int          SRC_WAKE    = 3;
    localparam int          SRC_PERIPH  = 4;
    localparam logic [TMR_W-1:0]  TMR_ZERO = 16'h0000;
    localparam logic [TMR_W-1:0]  TMR_ONE  = 16'h0001;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 4'h0;
    localparam logic [DUTY_W-1:0] DUTY_ONE  = 4'h1;
    localparam logic [SRC_W-1:0]  SRC_NONE  = 5'h00;
    localparam logic [PLANE_W-1:0] PLANE_ALL_ON = 4'hF;
    typedef enum logic [1:0] {PWR_ON, PWR_DOZE, PWR_STBY, PWR_SUSPEND_THROTTLE_OUT} pwr_state_t;
endpackage : apm_pkg

// File: rtl/idle_timer.sv
// one inactivity down-counter with reload
// assumes timeout is held steady by software while enabled
`timescale 1ns/10ps
module idle_timer
    import apm_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             enable_in,
    input  wire logic             activity_in,
    input  wire logic [TMR_W-1:0] timeout_in,
    output logic                  expire_out
);
    import apm_pkg::*;
    logic [TMR_W-1:0] count_q;
    logic [TMR_W-1:0] count_d;
    logic             expire_q;
    logic             expire_d;

    // ----------------------------------------
    // count down, reload on activity
    // ----------------------------------------
    always_comb
    begin
        count_d  = count_q;
        expire_d = 1'b0;
        if (!enable_in || activity_in)
        begin
            count_d = timeout_in;
        end
        else if (count_q == TMR_ONE)
        begin
            count_d  = TMR_ZERO;
            expire_d = 1'b1;
        end
        else if (count_q != TMR_ZERO)
        begin
            count_d = count_q - TMR_ONE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count_q  <= TMR_ZERO;
            expire_q <= 1'b0;
        end
        else
        begin
            count_q  <= count_d;
            expire_q <= expire_d;
        end
    end

    assign expire_out = expire_q;

    chk_expire_after_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        expire_q |-> $past(count_q) == TMR_ONE && $past(enable_in) && !$past(activity_in))
        else $error("timer expired without a full idle count");
    chk_reload_on_act: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        enable_in && activity_in |=> count_q == $past(timeout_in) && !expire_q)
        else $error("timer did not reload on activity");
endmodule : idle_timer

// File: dv/mgmt_core_model.sv
// model of the embedded core: reports its work drained some cycles into suspend
// assumes the manager's power state output drives pwr_state_in
`timescale 1ns/10ps
module mgmt_core_model
    import apm_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    input  wire apm_pkg::pwr_state_t pwr_state_in,
    input  wire logic [7:0]          drain_delay_in,
    output logic                     core_drained_out
);
    logic [7:0] wait_q;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wait_q           <= 8'h00;
            core_drained_out <= 1'b0;
        end
        else if (pwr_state_in == PWR_SUSPEND_THROTTLE_OUT)
        begin
            // finish current work, then report
            if (wait_q != drain_delay_in)
                wait_q <= wait_q + 8'h01;
            core_drained_out <= (wait_q == drain_delay_in);
        end
        else
        begin
            // fetch resumes where it stopped
            wait_q           <= 8'h00;
            core_drained_out <= 1'b0;
        end
    end
endmodule : mgmt_core_model

// File: dv/activity_power_manager_tb_top.sv
// self-checking bench for the activity power manager
// assumes apm_pkg and the core model are compiled before it
`timescale 1ns/10ps
module activity_power_manager_tb_top;
    import apm_pkg::*;
    logic               clk, rst_b, sys_act, hk_act, per_act, st_req, drained;
    logic               intr, thr, clk_stop, per_idle;
    logic [TMR_W-1:0]   t_doze, t_stby, t_suspend_throttle_out, t_hk, t_per;
    logic [SRC_W-1:0]   irq_en, irq_ack, status;
    logic [DUTY_W-1:0]  d_on, d_doze, d_stby;
    logic [PLANE_W-1:0] plane_off, plane_en;
    logic [7:0]         drain_dly;
    pwr_state_t         st_sel, state;
    int                 n_errors = 0;
    int                 total_checks = 0;

    activity_power_manager activity_power_manager_i (
        .clk_in(clk), .rst_b_in(rst_b), .sys_activity_in(sys_act),
        .hk_activity_in(hk_act), .periph_activity_in(per_act),
        .doze_timeout_in(t_doze), .stby_timeout_in(t_stby), .suspend_throttle_out_timeout_in(t_suspend_throttle_out),
        .hk_timeout_in(t_hk), .periph_timeout_in(t_per), .irq_enable_in(irq_en),
        .irq_ack_in(irq_ack), .state_req_in(st_req), .state_sel_in(st_sel),
        .throttle_on_in(d_on), .throttle_doze_in(d_doze), .throttle_stby_in(d_stby),
        .plane_off_in(plane_off), .core_drained_in(drained),
        .system_mgmt_interrupt_out(intr), .irq_status_out(status), .pwr_state_out(state),
        .suspend_throttle_out(thr), .core_clk_stop_out(clk_stop),
        .plane_enable_out(plane_en), .periph_idle_out(per_idle));
    mgmt_core_model mgmt_core_model_i (.clk_in(clk), .rst_b_in(rst_b),
        .pwr_state_in(state), .drain_delay_in(drain_dly), .core_drained_out(drained));

    // ------------------------------------------------------------
    // bench helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // request a state, check it, end on an edge
    task automatic go(input pwr_state_t s);
        @(posedge clk);
        st_req <= 1'b1;
        st_sel <= s;
        @(posedge clk);
        st_req <= 1'b0;
        #1 check("pwr_state", 16'(state), 16'(s));
        @(posedge clk);
    endtask : go

    task automatic ack(input logic [SRC_W-1:0] m);
        @(posedge clk);
        irq_ack <= m;
        @(posedge clk);
        irq_ack <= '0;
        tick(2);
    endtask : ack

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_timers;
        int first [3];
        first = '{0, 0, 0};
        @(posedge clk);
        repeat (8)
        begin
            sys_act <= 1'b0;
            tick(4);
            sys_act <= 1'b1;
            tick(1);
        end
        #1 check("status_reload", 16'(status), 16'h0000);
        @(posedge clk);
        sys_act <= 1'b0;
        for (int i = 1; i <= 30; i++)
        begin
            @(posedge clk);
            #1;
            for (int b = 0; b < 3; b++)
                if (status[b] && first[b] == 0)
                    first[b] = i;
        end
        check("doze_expiry", 16'(first[0] >= 6 && first[0] <= 11), 16'h0001);
        check("stby_expiry", 16'(first[1] >= 12 && first[1] <= 17), 16'h0001);
        check("suspend_throttle_out_expiry", 16'(first[2] >= 18 && first[2] <= 23), 16'h0001);
        check("irq_line", 16'(intr), 16'h0001);
        @(posedge clk);
        sys_act <= 1'b1;
        ack(5'h01);
        #1 check("status_partial_ack", 16'(status), 16'h0006);
        ack(5'h06);
        #1 check("irq_line_ack", 16'(intr), 16'h0000);
    endtask : t_timers

    task automatic t_wake;
        @(posedge clk);
        t_stby <= 16'h0000;
        t_suspend_throttle_out <= 16'h0000;
        for (int k = 1; k < 3; k++)
        begin
            @(posedge clk);
            sys_act <= 1'b0;
            go(pwr_state_t'(k));
            hk_act <= 1'b1;
            tick(2);
            hk_act <= 1'b0;
            tick(6);
            #1 check("hk_burst", 16'(status), 16'h0000);
            @(posedge clk);
            sys_act <= 1'b1;
            tick(4);
            #1 check("wake_src", 16'(status), 16'h0008);
            go(PWR_ON);
            ack(5'h08);
            #1 check("wake_ack", 16'(intr), 16'h0000);
        end
    endtask : t_wake

    task automatic t_suspend(input logic [7:0] dly);
        int n;
        n = 0;
        @(posedge clk);
        drain_dly <= dly;
        go(PWR_SUSPEND_THROTTLE_OUT);
        for (int i = 1; i <= 40; i++)
        begin
            @(posedge clk);
            #1;
            if (clk_stop === 1'b1 && n == 0)
                n = i;
        end
        check("clk_stop_wait", 16'(n >= dly && n <= dly + 4), 16'h0001);
        check("suspend_throttle_out_throttle", 16'(thr), 16'h0000);
        check("suspend_throttle_out_wake", 16'(status), 16'h0008);
        go(PWR_ON);
        #1 check("clk_restart", 16'(clk_stop), 16'h0000);
        ack(5'h08);
    endtask : t_suspend

    task automatic t_throttle;
        int lows;
        @(posedge clk);
        d_on   <= 4'h3;
        d_doze <= 4'h5;
        d_stby <= 4'h7;
        for (int k = 0; k < 3; k++)
        begin
            go(pwr_state_t'(k));
            tick(16);
            lows = 0;
            repeat (32)
            begin
                @(posedge clk);
                #1;
                if (thr === 1'b0)
                    lows++;
            end
            check("throttle_lows", 16'(lows), 16'(2 * (3 + 2 * k)));
        end
        go(PWR_ON);
        ack(5'h1F);
    endtask : t_throttle

    task automatic t_planes;
        logic [PLANE_W-1:0] p;
        for (int k = 0; k < 4; k++)
        begin
            p = 4'(5 * k);
            @(posedge clk);
            plane_off <= p;
            tick(2);
            #1 check("plane_enable", 16'(plane_en), 16'(PLANE_ALL_ON ^ p));
        end
    endtask : t_planes

    task automatic t_periph;
        int n;
        n = 0;
        @(posedge clk);
        per_act <= 1'b0;
        for (int i = 1; i <= 30; i++)
        begin
            @(posedge clk);
            #1;
            if (per_idle === 1'b1 && n == 0)
                n = i;
        end
        check("periph_idle_wait", 16'(n >= 8 && n <= 13), 16'h0001);
        check("periph_src", 16'(status), 16'h0010);
        @(posedge clk);
        per_act <= 1'b1;
        tick(3);
        #1 check("periph_busy", 16'(per_idle), 16'h0000);
        @(posedge clk);
        irq_en <= 5'h0F;
        tick(2);
        #1 check("periph_masked", 16'(status), 16'h0000);
        @(posedge clk);
        irq_en <= 5'h1F;
        ack(5'h10);
    endtask : t_periph

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done;
    end

    initial
    begin
        {rst_b, hk_act, st_req, irq_ack, plane_off} = '0;
        {sys_act, per_act} = 2'b11;
        {d_on, d_doze, d_stby} = '0;
        {t_doze, t_stby, t_suspend_throttle_out, t_hk, t_per} = {16'h0006, 16'h000C, 16'h0012, 16'h0014, 16'h0008};
        irq_en = 5'h1F;
        st_sel = PWR_ON;
        drain_dly = 8'h01;
        tick(5);
        #1 check("reset_outs", 16'({intr, status, state, thr, clk_stop, plane_en, per_idle}),
            16'({1'b0, 5'h00, 2'b00, 1'b1, 1'b0, 4'hF, 1'b0}));
        @(posedge clk);
        rst_b <= 1'b1;
        tick(2);
        t_timers;
        t_wake;
        t_suspend(8'h01);
        t_suspend(8'h0A);
        t_throttle;
        t_planes;
        t_periph;
        test_done;
    end
endmodule : activity_power_manager_tb_top
